// *** design/motor_pkg.sv ***
/*
 * shared constants and types for the dual full-bridge motor control block:
 * timing counts, register map, event bits and the packed signal groups.
 * assumes a single 20 MHz core clock and synchronous active-high reset.
 */
package motor_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int OFF_TIME_NS = 25000;
	localparam int BLANK_TIME_NS = 3000;
	localparam int DEAD_TIME_NS = 50;
	localparam int STANDBY_TIME_MS = 1;
	// off, blanking and dead times round up, none below one cycle; the standby count truncates
	localparam int OFF_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STANDBY_CYC = (STANDBY_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CLEAR = 8'h04;
	localparam logic [7:0] REG_IRQ_EN = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0c;
	localparam logic [7:0] REG_CONTROL = 8'h10;
	localparam logic [1:0] CONTROL_RESET = 2'h3;
	localparam int CTL_EN_A = 0;
	localparam int CTL_EN_B = 1;

	// event bits, shared by status, clear and enable
	localparam int EV_W = 6;
	localparam int EV_OCP_A = 0;
	localparam int EV_OCP_B = 1;
	localparam int EV_THERMAL = 2;
	localparam int EV_LOCKOUT = 3;
	localparam int EV_SBY_ENTER = 4;
	localparam int EV_SBY_EXIT = 5;

	// live state register fields
	localparam int ST_OCP_A = 0;
	localparam int ST_OCP_B = 1;
	localparam int ST_THERMAL = 2;
	localparam int ST_LOCKOUT = 3;
	localparam int ST_STANDBY = 4;
	localparam int ST_PHASE_A = 5;
	localparam int ST_PHASE_B = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_DRIVE = 3'b001,
		PH_FAST = 3'b010,
		PH_DEAD = 3'b011,
		PH_SLOW = 3'b100
	} chop_phase_t;

	typedef struct packed {
		logic first;
		logic second;
	} bridge_cmd_t;

	typedef struct packed {
		logic trip;
		logic zero_current;
		logic short_det;
	} bridge_sense_t;

	typedef struct packed {
		logic first_src;
		logic first_snk;
		logic second_src;
		logic second_snk;
	} bridge_gate_t;

endpackage

// *** design/standby_timer.sv ***
/*
 * idle timer: raises standby once all control inputs stay low past the
 * programmed count; drops it in the cycle after any input goes high.
 * assumes the idle level is already synchronous to the clock.
 */
`timescale 1ns/1ps
module standby_timer #(
	parameter int CYC = 20000,
	parameter int W = 16
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic all_low_i,
	output logic standby_o
);
	logic [W-1:0] cnt_q;

	// count continuous idle cycles, saturating
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !all_low_i) begin
			cnt_q <= '0;
		end else if (cnt_q != W'(CYC)) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	// enter only after the full idle count has passed
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !all_low_i) begin
			standby_o <= 1'b0;
		end else if (cnt_q == W'(CYC)) begin
			standby_o <= 1'b1;
		end
	end
endmodule // standby_timer

// *** design/bridge_chopper.sv ***
/*
 * one full bridge: decodes the two control inputs, runs the fixed
 * off-time current chopper with mixed decay, dead time, blanking and
 * synchronous rectification, and registers the four switch enables.
 * assumes trip, zero-current and control levels synchronous to the clock.
 */
`timescale 1ns/1ps
module bridge_chopper
	import motor_pkg::*;
#(
	parameter int OFF = 500,
	parameter int DEAD = 1,
	parameter int BLANK = 60
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic enable_i,
	input motor_pkg::bridge_cmd_t cmd_i,
	input motor_pkg::bridge_sense_t sense_i,
	output motor_pkg::bridge_gate_t gate_o,
	output motor_pkg::chop_phase_t phase_o
);
	localparam int FAST = OFF / 2;

	chop_phase_t ph_q;
	bridge_cmd_t cmd_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] dcnt_q;
	logic sr_q;
	logic drive_cmd;
	logic fwd;
	bridge_gate_t gate_d;

	assign drive_cmd = cmd_i.first ^ cmd_i.second;
	assign fwd = cmd_i.first & ~cmd_i.second;
	assign phase_o = ph_q;

	// chopper sequence: drive, fast, dead, slow, back to drive
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !enable_i) begin
			ph_q <= PH_IDLE;
			cnt_q <= '0;
			dcnt_q <= '0;
		end else if (!drive_cmd) begin
			ph_q <= PH_IDLE;
			cnt_q <= '0;
		end else if (ph_q == PH_IDLE || cmd_i != cmd_q) begin
			ph_q <= PH_DRIVE;
			cnt_q <= '0;
		end else begin
			case (ph_q)
				PH_DRIVE: begin
					if (cnt_q < CNT_W'(BLANK)) begin
						cnt_q <= cnt_q + CNT_W'(1);
					end else if (sense_i.trip) begin
						ph_q <= PH_FAST;
						cnt_q <= '0;
					end
				end
				PH_FAST: begin
					cnt_q <= cnt_q + CNT_W'(1);
					if (cnt_q == CNT_W'(FAST - 1)) begin
						ph_q <= PH_DEAD;
						dcnt_q <= '0;
					end
				end
				PH_DEAD: begin
					cnt_q <= cnt_q + CNT_W'(1);
					dcnt_q <= dcnt_q + CNT_W'(1);
					if (dcnt_q == CNT_W'(DEAD - 1)) begin
						ph_q <= PH_SLOW;
					end
				end
				PH_SLOW: begin
					cnt_q <= cnt_q + CNT_W'(1);
					if (cnt_q >= CNT_W'(OFF - 1)) begin
						ph_q <= PH_DRIVE;
						cnt_q <= '0;
					end
				end
				default: begin
					ph_q <= PH_IDLE;
				end
			endcase
		end
	end

	// remember the command to restart blanking on a change
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cmd_q <= '0;
		end else begin
			cmd_q <= cmd_i;
		end
	end

	// rectifier armed at each decay start unless current is already zero,
	// dropped at zero current or dead time, so load current never reverses
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sr_q <= 1'b0;
		end else if (ph_q == PH_DRIVE && cnt_q >= CNT_W'(BLANK) && sense_i.trip &&
				!sense_i.zero_current) begin
			sr_q <= 1'b1;
		end else if (ph_q == PH_DEAD && dcnt_q == CNT_W'(DEAD - 1) &&
				!sense_i.zero_current) begin
			sr_q <= 1'b1;
		end else if (ph_q == PH_DEAD || sense_i.zero_current) begin
			sr_q <= 1'b0;
		end
	end

	// switch decode per phase and direction
	always_comb begin
		gate_d = '0;
		if (enable_i) begin
			case (ph_q)
				PH_FAST: begin
					// opposite diagonal conducts only while rectifying
					gate_d.first_snk = fwd & sr_q;
					gate_d.second_src = fwd & sr_q;
					gate_d.first_src = ~fwd & sr_q;
					gate_d.second_snk = ~fwd & sr_q;
				end
				PH_DEAD: begin
					gate_d = '0;
				end
				PH_SLOW: begin
					gate_d.first_snk = fwd | sr_q;
					gate_d.second_snk = ~fwd | sr_q;
				end
				default: begin
					if (cmd_i.first && cmd_i.second) begin
						gate_d.first_snk = 1'b1;
						gate_d.second_snk = 1'b1;
					end else if (fwd) begin
						gate_d.first_src = 1'b1;
						gate_d.second_snk = 1'b1;
					end else if (drive_cmd) begin
						gate_d.second_src = 1'b1;
						gate_d.first_snk = 1'b1;
					end
					// both low leaves all four off
				end
			endcase
		end
	end

	// registered switch enables
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			gate_o <= '0;
		end else begin
			gate_o <= gate_d;
		end
	end
endmodule // bridge_chopper

// *** design/dual_bridge_motor_control.sv ***
/*
 * top of the dual full-bridge motor control block: two chopper bridges,
 * idle standby timer, overcurrent, thermal and lockout protection, a small
 * register file with sticky event status and one level interrupt.
 * assumes all pins synchronous to core_clk_i; comparator, short, thermal
 * and lockout indications come from analog monitors outside this logic.
 */
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module dual_bridge_motor_control
	import motor_pkg::*;
#(
	parameter int STANDBY_COUNT = motor_pkg::STANDBY_CYC,
	parameter int OFF_COUNT = motor_pkg::OFF_CYC,
	parameter int DEAD_COUNT = motor_pkg::DEAD_CYC,
	parameter int BLANK_COUNT = motor_pkg::BLANK_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic bridge_a_ctrl_first_i,
	input wire logic bridge_a_ctrl_second_i,
	input wire logic bridge_b_ctrl_first_i,
	input wire logic bridge_b_ctrl_second_i,
	input motor_pkg::bridge_sense_t bridge_a_sense_i,
	input motor_pkg::bridge_sense_t bridge_b_sense_i,
	input wire logic over_temp_i,
	input wire logic thermal_recovered_i,
	input wire logic supply_lockout_i,
	input wire logic load_supply_restart_i,
	input wire logic [motor_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [motor_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [motor_pkg::DATA_W-1:0] reg_rdata_o,
	output motor_pkg::bridge_gate_t bridge_a_drive_o,
	output motor_pkg::bridge_gate_t bridge_b_drive_o,
	output logic charge_pump_en_o,
	output logic regulator_en_o,
	output logic standby_o,
	output logic irq_o
);
	import motor_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	bridge_cmd_t cmd_a;
	bridge_cmd_t cmd_b;
	chop_phase_t phase_a;
	chop_phase_t phase_b;
	logic all_low;
	logic standby;
	logic standby_prev_q;
	logic wake_pulse;
	logic sleep_pulse;
	logic ocp_a_q;
	logic ocp_b_q;
	logic thermal_q;
	logic lockout_prev_q;
	logic lockout_rise;
	logic ocp_a_rise;
	logic ocp_b_rise;
	logic thermal_rise;
	logic thermal_prev_q;
	logic ocp_a_prev_q;
	logic ocp_b_prev_q;
	logic fault_clear;
	logic en_a;
	logic en_b;
	logic [1:0] control_q;
	logic [EV_W-1:0] status_q;
	logic [EV_W-1:0] irq_en_q;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clear_bits;
	logic [DATA_W-1:0] state_word;
	logic [DATA_W-1:0] rdata_d;
	logic pump_en_q;

	// register address compare, used by every access path
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// control input grouping
	// ----------------------------------------------------------------
	// pack each bridge's pair of control pins
	assign cmd_a.first = bridge_a_ctrl_first_i;
	assign cmd_a.second = bridge_a_ctrl_second_i;
	assign cmd_b.first = bridge_b_ctrl_first_i;
	assign cmd_b.second = bridge_b_ctrl_second_i;

	// idle when all four control pins are low
	assign all_low = ~(bridge_a_ctrl_first_i | bridge_a_ctrl_second_i |
		bridge_b_ctrl_first_i | bridge_b_ctrl_second_i);

	// ----------------------------------------------------------------
	// standby
	// ----------------------------------------------------------------
	// idle timer into low-power standby
	standby_timer #(
		.CYC(STANDBY_COUNT),
		.W(CNT_W)
	) u_standby (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.all_low_i(all_low),
		.standby_o(standby)
	);

	// edges of standby for fault release and events
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			standby_prev_q <= 1'b0;
		end else begin
			standby_prev_q <= standby;
		end
	end

	assign wake_pulse = standby_prev_q & ~standby;
	assign sleep_pulse = ~standby_prev_q & standby;

	// charge pump and regulator off while asleep; host waits after wake
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pump_en_q <= 1'b1;
		end else begin
			pump_en_q <= ~standby;
		end
	end

	assign charge_pump_en_o = pump_en_q;
	assign regulator_en_o = pump_en_q;
	assign standby_o = standby_prev_q;

	// ----------------------------------------------------------------
	// protection
	// ----------------------------------------------------------------
	// only wake from standby or a load supply cycle releases an overcurrent fault
	assign fault_clear = wake_pulse | load_supply_restart_i;

	// per-channel overcurrent latch, a new short wins over the clear
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ocp_a_q <= 1'b0;
		end else if (bridge_a_sense_i.short_det) begin
			ocp_a_q <= 1'b1;
		end else if (fault_clear) begin
			ocp_a_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ocp_b_q <= 1'b0;
		end else if (bridge_b_sense_i.short_det) begin
			ocp_b_q <= 1'b1;
		end else if (fault_clear) begin
			ocp_b_q <= 1'b0;
		end
	end

	// thermal shutdown held until the recovery level is reported
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			thermal_q <= 1'b0;
		end else if (over_temp_i) begin
			thermal_q <= 1'b1;
		end else if (thermal_recovered_i) begin
			thermal_q <= 1'b0;
		end
	end

	// bridge enables: control bit, own fault, shared shutdowns
	assign en_a = control_q[CTL_EN_A] & ~ocp_a_q & ~thermal_q &
		~supply_lockout_i & ~standby;
	assign en_b = control_q[CTL_EN_B] & ~ocp_b_q & ~thermal_q &
		~supply_lockout_i & ~standby;

	// ----------------------------------------------------------------
	// bridges
	// ----------------------------------------------------------------
	bridge_chopper #(
		.OFF(OFF_COUNT),
		.DEAD(DEAD_COUNT),
		.BLANK(BLANK_COUNT)
	) u_bridge_a (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.enable_i(en_a),
		.cmd_i(cmd_a),
		.sense_i(bridge_a_sense_i),
		.gate_o(bridge_a_drive_o),
		.phase_o(phase_a)
	);

	bridge_chopper #(
		.OFF(OFF_COUNT),
		.DEAD(DEAD_COUNT),
		.BLANK(BLANK_COUNT)
	) u_bridge_b (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.enable_i(en_b),
		.cmd_i(cmd_b),
		.sense_i(bridge_b_sense_i),
		.gate_o(bridge_b_drive_o),
		.phase_o(phase_b)
	);

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	// previous levels for rising-edge events
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			lockout_prev_q <= 1'b0;
			thermal_prev_q <= 1'b0;
			ocp_a_prev_q <= 1'b0;
			ocp_b_prev_q <= 1'b0;
		end else begin
			lockout_prev_q <= supply_lockout_i;
			thermal_prev_q <= thermal_q;
			ocp_a_prev_q <= ocp_a_q;
			ocp_b_prev_q <= ocp_b_q;
		end
	end

	assign lockout_rise = supply_lockout_i & ~lockout_prev_q;
	assign thermal_rise = thermal_q & ~thermal_prev_q;
	assign ocp_a_rise = ocp_a_q & ~ocp_a_prev_q;
	assign ocp_b_rise = ocp_b_q & ~ocp_b_prev_q;

	// event vector in status layout
	always_comb begin
		events = '0;
		events[EV_OCP_A] = ocp_a_rise;
		events[EV_OCP_B] = ocp_b_rise;
		events[EV_THERMAL] = thermal_rise;
		events[EV_LOCKOUT] = lockout_rise;
		events[EV_SBY_ENTER] = sleep_pulse;
		events[EV_SBY_EXIT] = wake_pulse;
	end

	// write to the clear register names bits to drop
	assign clear_bits = (reg_we_i && hit(reg_addr_i, REG_CLEAR)) ?
		reg_wdata_i[EV_W-1:0] : '0;

	// sticky status, a new event beats a clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clear_bits) | events;
		end
	end

	// level interrupt while any enabled status bit is set
	assign irq_o = |(status_q & irq_en_q);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// interrupt enable register
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			irq_en_q <= '0;
		end else if (reg_we_i && hit(reg_addr_i, REG_IRQ_EN)) begin
			irq_en_q <= reg_wdata_i[EV_W-1:0];
		end
	end

	// per-bridge enable bits steering the choppers
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			control_q <= CONTROL_RESET;
		end else if (reg_we_i && hit(reg_addr_i, REG_CONTROL)) begin
			control_q <= reg_wdata_i[1:0];
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// live protection and phase state
	always_comb begin
		state_word = '0;
		state_word[ST_OCP_A] = ocp_a_q;
		state_word[ST_OCP_B] = ocp_b_q;
		state_word[ST_THERMAL] = thermal_q;
		state_word[ST_LOCKOUT] = supply_lockout_i;
		state_word[ST_STANDBY] = standby;
		state_word[ST_PHASE_A +: 3] = phase_a;
		state_word[ST_PHASE_B +: 3] = phase_b;
	end

	// read mux; clear register and unmapped offsets read zero
	always_comb begin
		rdata_d = '0;
		if (hit(reg_addr_i, REG_STATUS)) begin
			rdata_d[EV_W-1:0] = status_q;
		end else if (hit(reg_addr_i, REG_IRQ_EN)) begin
			rdata_d[EV_W-1:0] = irq_en_q;
		end else if (hit(reg_addr_i, REG_STATE)) begin
			rdata_d = state_word;
		end else if (hit(reg_addr_i, REG_CONTROL)) begin
			rdata_d[1:0] = control_q;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_re_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule // dual_bridge_motor_control

// *** verif/motor_ctrl_sva.sv ***
/*
 * port checker for the dual bridge control block.
 * assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module motor_ctrl_sva #(
	parameter int STANDBY_COUNT = 50
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic bridge_a_ctrl_first_i,
	input wire logic bridge_a_ctrl_second_i,
	input wire logic bridge_b_ctrl_first_i,
	input wire logic bridge_b_ctrl_second_i,
	input motor_pkg::bridge_sense_t bridge_a_sense_i,
	input wire logic over_temp_i,
	input wire logic supply_lockout_i,
	input wire logic reg_re_i,
	input logic [motor_pkg::DATA_W-1:0] reg_rdata_o,
	input motor_pkg::bridge_gate_t bridge_a_drive_o,
	input motor_pkg::bridge_gate_t bridge_b_drive_o,
	input logic charge_pump_en_o,
	input logic regulator_en_o,
	input logic standby_o
);
	import motor_pkg::*;
	logic [3:0] ga;
	logic [3:0] gb;
	logic [1:0] a_cmd;
	logic idle;
	logic [15:0] idle_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// flat views of gates and commands
	assign ga = bridge_a_drive_o;
	assign gb = bridge_b_drive_o;
	assign a_cmd = {bridge_a_ctrl_first_i, bridge_a_ctrl_second_i};
	assign idle = ~|{a_cmd, bridge_b_ctrl_first_i, bridge_b_ctrl_second_i};
	// count of consecutive idle cycles, saturating
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !idle) begin
			idle_q <= 16'h0;
		end else if (idle_q != 16'hffff) begin
			idle_q <= idle_q + 16'h1;
		end
	end
	property p_coast; a_cmd == 2'h0 [*2] |=> ga == 4'h0; endproperty
	a_coast: assert property (p_coast) else $error("coast gates not off");
	property p_brake; a_cmd == 2'h3 [*2] |=> ga inside {4'h5, 4'h0}; endproperty
	a_brake: assert property (p_brake) else $error("brake gates wrong");
	property p_fwd; a_cmd == 2'h2 [*2] |=> ga inside {4'h9, 4'h6, 4'h5, 4'h4, 4'h0}; endproperty
	a_fwd: assert property (p_fwd) else $error("forward gates wrong");
	property p_lock; supply_lockout_i |=> ga == 4'h0 && gb == 4'h0; endproperty
	a_lock: assert property (p_lock) else $error("gates on in lockout");
	property p_therm; over_temp_i |-> ##2 ga == 4'h0 && gb == 4'h0; endproperty
	a_therm: assert property (p_therm) else $error("gates on when hot");
	property p_short; bridge_a_sense_i.short_det |-> ##2 ga == 4'h0; endproperty
	a_short: assert property (p_short) else $error("gates on after short");
	property p_sby_rise; $rose(standby_o) |-> idle_q >= 16'(STANDBY_COUNT); endproperty
	a_sby_rise: assert property (p_sby_rise) else $error("standby too early");
	property p_sby_drop; standby_o && !idle |-> ##[1:2] !standby_o; endproperty
	a_sby_drop: assert property (p_sby_drop) else $error("standby not left");
	property p_sby_pwr; $rose(standby_o) |-> ##[0:1] !charge_pump_en_o && !regulator_en_o;
	endproperty
	a_sby_pwr: assert property (p_sby_pwr) else $error("pump on in standby");
	property p_rdata; !$past(reg_re_i) |-> reg_rdata_o == '0; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
	property p_shoot; !(ga[3] && ga[2]) && !(ga[1] && ga[0]) && !(gb[3] && gb[2])
		&& !(gb[1] && gb[0]); endproperty
	a_shoot: assert property (p_shoot) else $error("leg shoot-through");
endmodule // motor_ctrl_sva

bind dual_bridge_motor_control motor_ctrl_sva #(.STANDBY_COUNT(STANDBY_COUNT)) u_sva (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.bridge_a_ctrl_first_i(bridge_a_ctrl_first_i),
	.bridge_a_ctrl_second_i(bridge_a_ctrl_second_i),
	.bridge_b_ctrl_first_i(bridge_b_ctrl_first_i),
	.bridge_b_ctrl_second_i(bridge_b_ctrl_second_i),
	.bridge_a_sense_i(bridge_a_sense_i), .over_temp_i(over_temp_i),
	.supply_lockout_i(supply_lockout_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
	.bridge_a_drive_o(bridge_a_drive_o), .bridge_b_drive_o(bridge_b_drive_o),
	.charge_pump_en_o(charge_pump_en_o), .regulator_en_o(regulator_en_o),
	.standby_o(standby_o));

// *** verif/host_pwm_model.sv ***
/*
 * host model: drives the four bridge control pins from requests,
 * wakes the block from standby and lets the pump settle first.
 * assumes the bench clock and reset of the block.
 */
`timescale 1ns/1ps
module host_pwm_model #(
	parameter int WAKE_CYC = 4000
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic standby_i,
	input motor_pkg::bridge_cmd_t req_a_i,
	input motor_pkg::bridge_cmd_t req_b_i,
	output motor_pkg::bridge_cmd_t pin_a_o,
	output motor_pkg::bridge_cmd_t pin_b_o,
	output logic busy_o
);
	import motor_pkg::*;
	int wait_q;
	// wake pulse, settle wait with pins low, then forward requests
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wait_q <= 0;
			pin_a_o <= '0;
			pin_b_o <= '0;
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
			pin_a_o <= '0;
			pin_b_o <= '0;
		end else if (standby_i && (req_a_i != 2'h0 || req_b_i != 2'h0)) begin
			pin_a_o <= 2'h2;
			pin_b_o <= '0;
			wait_q <= WAKE_CYC;
		end else begin
			pin_a_o <= req_a_i;
			pin_b_o <= req_b_i;
		end
	end
	assign busy_o = wait_q > 0;
endmodule // host_pwm_model

// *** verif/tb.sv ***
/*
 * self-checking bench for the dual bridge block with a host model.
 * assumes shortened timer counts given to the block below.
 */
`timescale 1ns/1ps
module tb;
	import motor_pkg::*;
	localparam int SBY_N = 50;
	localparam int OFF_N = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	bridge_cmd_t req_a, req_b, pin_a, pin_b;
	bridge_sense_t sa, sb;
	bridge_gate_t ga, gb;
	logic ot, tr, lk, lsr, we, re, cp, rg, sby, irq, busy;
	logic [7:0] addr;
	logic [31:0] wd, rd;
	int n_errors = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	dual_bridge_motor_control #(.STANDBY_COUNT(SBY_N), .OFF_COUNT(OFF_N), .DEAD_COUNT(1),
		.BLANK_COUNT(4)) dut (.core_clk_i(clk), .sys_rst_i(rst),
		.bridge_a_ctrl_first_i(pin_a.first), .bridge_a_ctrl_second_i(pin_a.second),
		.bridge_b_ctrl_first_i(pin_b.first), .bridge_b_ctrl_second_i(pin_b.second),
		.bridge_a_sense_i(sa), .bridge_b_sense_i(sb), .over_temp_i(ot),
		.thermal_recovered_i(tr), .supply_lockout_i(lk), .load_supply_restart_i(lsr),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd),
		.bridge_a_drive_o(ga), .bridge_b_drive_o(gb), .charge_pump_en_o(cp),
		.regulator_en_o(rg), .standby_o(sby), .irq_o(irq));
	host_pwm_model #(.WAKE_CYC(8)) host (.core_clk_i(clk), .sys_rst_i(rst), .standby_i(sby),
		.req_a_i(req_a), .req_b_i(req_b), .pin_a_o(pin_a), .pin_b_o(pin_b), .busy_o(busy));
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
		chk(rd, e);
	endtask
	task automatic drive(input bridge_cmd_t a, input bridge_cmd_t b);
		@(posedge clk);
		req_a <= a;
		req_b <= b;
		cyc(5);
	endtask
	// reset values, read-only and unmapped places
	task automatic t_regs;
		rdc(REG_CONTROL, 32'h3);
		rdc(REG_STATUS, 32'h0);
		wr(REG_STATUS, 32'hffffffff);
		rdc(REG_STATUS, 32'h0);
		rdc(REG_CLEAR, 32'h0);
		rdc(8'h14, 32'h0);
		wr(REG_IRQ_EN, 32'h3f);
		rdc(REG_IRQ_EN, 32'h3f);
		$display("test regs done");
	endtask
	// every input pattern on both bridges
	task automatic t_truth;
		bridge_cmd_t p[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
		logic [3:0] g[4] = '{4'h9, 4'h6, 4'h5, 4'h0};
		for (int i = 0; i < 4; i++) begin
			drive(p[i], p[3-i]);
			chk(ga, g[i]);
			chk(gb, g[3-i]);
		end
		$display("test truth done");
	endtask
	// blanked trip, then one off-time on each bridge
	task automatic t_chop(input logic zc);
		logic [15:0] ma, mb;
		int n;
		ma = '0;
		mb = '0;
		n = 0;
		drive(2'h0, 2'h0);
		@(posedge clk);
		req_a <= 2'h2;
		req_b <= 2'h1;
		cyc(2);
		sa.trip <= 1'b1;
		sb.trip <= 1'b1;
		cyc(2);
		sa.trip <= 1'b0;
		sb.trip <= 1'b0;
		cyc(6);
		chk(ga, 4'h9);
		chk(gb, 4'h6);
		sa <= '{1'b1, zc, 1'b0};
		sb <= '{1'b1, zc, 1'b0};
		@(posedge clk);
		sa.trip <= 1'b0;
		sb.trip <= 1'b0;
		for (int i = 0; i < 3 * OFF_N; i++) begin
			@(posedge clk);
			if (ga !== 4'h9) begin
				ma[ga] = 1'b1;
				n++;
			end
			if (gb !== 4'h6) mb[gb] = 1'b1;
		end
		sa <= '0;
		sb <= '0;
		chk(n, OFF_N);
		chk(ma, zc ? 16'h0011 : 16'h0061);
		chk(mb, zc ? 16'h0003 : 16'h0221);
		if (zc) chk({ma[4], mb[1]}, 2'h3);
		$display("test chop done");
	endtask
	// lockout with interrupt, thermal and overcurrent
	task automatic t_prot;
		wr(REG_IRQ_EN, 32'h1 << EV_LOCKOUT);
		@(posedge clk);
		lk <= 1'b1;
		cyc(3);
		chk({ga, gb}, 8'h0);
		chk(irq, 1'b1);
		lk <= 1'b0;
		cyc(4);
		chk({ga, gb}, 8'h96);
		wr(REG_CLEAR, 32'h1 << EV_LOCKOUT);
		cyc(1);
		chk(irq, 1'b0);
		ot <= 1'b1;
		@(posedge clk);
		ot <= 1'b0;
		cyc(6);
		chk({ga, gb}, 8'h0);
		tr <= 1'b1;
		@(posedge clk);
		tr <= 1'b0;
		cyc(5);
		chk({ga, gb}, 8'h96);
		sa.short_det <= 1'b1;
		@(posedge clk);
		sa.short_det <= 1'b0;
		cyc(30);
		chk({ga, gb}, 8'h06);
		lsr <= 1'b1;
		@(posedge clk);
		lsr <= 1'b0;
		cyc(5);
		chk({ga, gb}, 8'h96);
		$display("test prot done");
	endtask
	// idle into standby, wake clears a latched fault
	task automatic t_standby;
		int i;
		sa.short_det <= 1'b1;
		@(posedge clk);
		sa.short_det <= 1'b0;
		@(posedge clk);
		req_a <= 2'h0;
		req_b <= 2'h0;
		for (i = 0; i < 4 * SBY_N && sby !== 1'b1; i++) @(posedge clk);
		chk(i > SBY_N && i < SBY_N + 6, 1'b1);
		cyc(2);
		chk({cp, rg}, 2'h0);
		drive(2'h2, 2'h1);
		for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge clk);
		cyc(5);
		chk({sby, cp, rg}, 3'h3);
		chk({ga, gb}, 8'h96);
		rdc(REG_STATUS, 32'h35);
		$display("test standby done");
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		{req_a, req_b, sa, sb, ot, tr, lk, lsr, we, re, addr, wd} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_truth();
		t_chop(1'b0);
		t_chop(1'b1);
		t_prot();
		t_standby();
		final_report();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule // tb
